// *** logic/irq_pkg.sv ***
package irq_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_STATUS_CONTROL = 8'h1D;
    localparam logic [7:0] IDX_OPTION_TWO     = 8'h1E;
    localparam logic [7:0] IDX_BREAK_CONTROL  = 8'h1F;

    localparam logic [7:0] ADR_STATUS_CONTROL = {IDX_STATUS_CONTROL[5:0], 2'b00};
    localparam logic [7:0] ADR_OPTION_TWO     = {IDX_OPTION_TWO[5:0], 2'b00};
    localparam logic [7:0] ADR_BREAK_CONTROL  = {IDX_BREAK_CONTROL[5:0], 2'b00};

    // Status/control field positions
    localparam int BIT_MODE = 0;
    localparam int BIT_MASK = 1;
    localparam int BIT_ACK  = 2;
    localparam int BIT_PEND = 3;

    // Option register two and break control field positions
    localparam int BIT_PULLUP_DISABLE = 0;
    localparam int BIT_BREAK_CLEAR_EN = 7;

    localparam logic [7:0]  REG_RESET  = 8'h00;
    localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/100ps

module pin_sync
(
    input  wire logic i_clk,      // System clock
    input  wire logic i_srst,     // Synchronous reset, active high
    input  wire logic i_pin,      // Asynchronous pin level
    output logic      o_level_q,  // Synchronised level
    output logic      o_fall      // One-cycle pulse on a falling edge
);

    logic       meta_q;
    logic       meta_d;
    logic       level_d;
    logic       hist_q;
    logic       hist_d;
    logic [1:0] armed_q;
    logic [1:0] armed_d;

    // Stages restart at the idle high level, but the history arms only
    // once both hold real pin samples: a pin held low through reset
    // must not look like a fresh falling edge
    always_comb
    begin
        meta_d  = i_pin;
        level_d = meta_q;
        armed_d = {armed_q[0], 1'b1};
        hist_d  = o_level_q & armed_q[1];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            meta_q    <= 1'b1;
            o_level_q <= 1'b1;
            hist_q    <= 1'b0;
            armed_q   <= 2'h0;
        end
        else
        begin
            meta_q    <= meta_d;
            o_level_q <= level_d;
            hist_q    <= hist_d;
            armed_q   <= armed_d;
        end
    end

    // Only the second stage and its history are compared
    assign o_fall = hist_q & ~o_level_q;

endmodule

// *** logic/external_irq_latch.sv ***
`timescale 1ns/100ps

module external_irq_latch
(
    input  wire logic        i_sys_clk,         // 20 MHz system clock
    input  wire logic        i_srst,            // Sync reset, active high
    input  wire logic        i_wb_cyc,          // Wishbone cycle
    input  wire logic        i_wb_stb,          // Wishbone strobe
    input  wire logic        i_wb_we,           // Wishbone write enable
    input  wire logic [7:0]  i_wb_adr,          // Wishbone byte address
    input  wire logic [31:0] i_wb_dat,          // Wishbone write data
    input  wire logic [3:0]  i_wb_sel,          // Wishbone byte selects
    output logic [31:0]      o_wb_dat,          // Wishbone read data
    output logic             o_wb_ack,          // Wishbone acknowledge
    input  wire logic        i_irq_pin_n,       // Interrupt pin, active low
    input  wire logic        i_vector_fetch,    // CPU fetches this vector
    input  wire logic        i_break_state,     // System is in break state
    output logic             o_irq_request,     // To interrupt priority logic
    output logic             o_pullup_enable,   // Pin pull-up connected
    output logic             o_pin_level        // Pin level for branches
);

    logic        pin_level;
    logic        pin_fall;
    logic        pin_low;

    pin_sync u_pin_sync
    (
        .i_clk     (i_sys_clk),
        .i_srst    (i_srst),
        .i_pin     (i_irq_pin_n),
        .o_level_q (pin_level),
        .o_fall    (pin_fall)
    );

    assign pin_low = ~pin_level;

    // Bus slave: one cycle of latency, ack held for a single cycle
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic        bus_req;
    logic        wr_now;
    logic        hit_sc;
    logic        hit_opt;
    logic        hit_brk;
    logic [7:0]  sc_read;

    logic        mask_q;
    logic        mask_d;
    logic        mode_q;
    logic        mode_d;
    logic        pud_q;
    logic        pud_d;
    logic        break_clear_enable_q;
    logic        break_clear_enable_d;

    logic        latch_q;
    logic        latch_d;
    logic        ack_seen_q;
    logic        ack_seen_d;
    logic        irq_q;
    logic        irq_d;
    logic        pullup_q;
    logic        pullup_d;
    logic        level_q;
    logic        level_d;

    logic        sw_ack;
    logic        clear_req;
    logic        hold_low;

    assign bus_req = i_wb_cyc & i_wb_stb & ~ack_q;
    assign hit_sc  = (i_wb_adr == irq_pkg::ADR_STATUS_CONTROL);
    assign hit_opt = (i_wb_adr == irq_pkg::ADR_OPTION_TWO);
    assign hit_brk = (i_wb_adr == irq_pkg::ADR_BREAK_CONTROL);

    // Writes land at the edge where the master samples ack
    assign wr_now  = ack_q & i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0];

    always_comb
    begin
        sc_read = irq_pkg::REG_RESET;
        sc_read[irq_pkg::BIT_PEND] = latch_q;
        sc_read[irq_pkg::BIT_ACK]  = 1'b0;
        sc_read[irq_pkg::BIT_MASK] = mask_q;
        sc_read[irq_pkg::BIT_MODE] = mode_q;
    end

    always_comb
    begin
        ack_d  = bus_req;
        rdat_d = irq_pkg::READ_ZERO;
        if (bus_req && !i_wb_we)
        begin
            if (hit_sc)
            begin
                rdat_d[7:0] = sc_read;
            end
            else if (hit_opt)
            begin
                rdat_d[irq_pkg::BIT_PULLUP_DISABLE] = pud_q;
            end
            else if (hit_brk)
            begin
                rdat_d[irq_pkg::BIT_BREAK_CLEAR_EN] = break_clear_enable_q;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            ack_q  <= 1'b0;
            rdat_q <= irq_pkg::READ_ZERO;
        end
        else
        begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // Software-written control bits
    always_comb
    begin
        mask_d = mask_q;
        mode_d = mode_q;
        pud_d  = pud_q;
        break_clear_enable_d = break_clear_enable_q;
        if (wr_now && hit_sc)
        begin
            mask_d = i_wb_dat[irq_pkg::BIT_MASK];
            mode_d = i_wb_dat[irq_pkg::BIT_MODE];
        end
        if (wr_now && hit_opt)
        begin
            pud_d = i_wb_dat[irq_pkg::BIT_PULLUP_DISABLE];
        end
        if (wr_now && hit_brk)
        begin
            break_clear_enable_d = i_wb_dat[irq_pkg::BIT_BREAK_CLEAR_EN];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            mask_q <= 1'b0;
            mode_q <= 1'b0;
            pud_q  <= 1'b0;
            break_clear_enable_q <= 1'b0;
        end
        else
        begin
            mask_q <= mask_d;
            mode_q <= mode_d;
            pud_q  <= pud_d;
            break_clear_enable_q <= break_clear_enable_d;
        end
    end

    // Acknowledge is a strobe only; its bit reads zero, and only ack_seen_q remembers it while hold_low
    assign sw_ack = wr_now & hit_sc & i_wb_dat[irq_pkg::BIT_ACK];

    // Break protection guards software only, never the vector fetch
    assign clear_req = i_vector_fetch
                     | (sw_ack & (~i_break_state | break_clear_enable_q));

    // Level mode keeps the request alive while the pin is low
    assign hold_low = mode_q & pin_low;

    always_comb
    begin
        latch_d    = latch_q;
        ack_seen_d = 1'b0;
        if ((clear_req || ack_seen_q) && !hold_low)
        begin
            latch_d = 1'b0;
        end
        // A falling-edge set wins over a clear landing in the same cycle; the level set does not
        if (pin_fall || (hold_low && !ack_seen_q && !clear_req))
        begin
            latch_d = 1'b1;
        end
        if (pin_fall)
        begin
            latch_d = 1'b1;
        end
        // Remember an early acknowledge until the pin returns high
        if (hold_low && latch_q && (clear_req || ack_seen_q))
        begin
            ack_seen_d = 1'b1;
        end
        irq_d    = latch_q & ~mask_q;
        pullup_d = ~pud_q;
        level_d  = pin_level;
    end

    // A latch cleared in break simply stays low; no restore on exit
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            latch_q    <= 1'b0;
            ack_seen_q <= 1'b0;
            irq_q      <= 1'b0;
            pullup_q   <= 1'b1;
            level_q    <= 1'b1;
        end
        else
        begin
            latch_q    <= latch_d;
            ack_seen_q <= ack_seen_d;
            irq_q      <= irq_d;
            pullup_q   <= pullup_d;
            level_q    <= level_d;
        end
    end

    // CPU applies its own global mask and vector on top of this
    assign o_irq_request   = irq_q;
    assign o_pullup_enable = pullup_q;
    assign o_pin_level     = level_q;

    default clocking cb @(posedge i_sys_clk);
    endclocking

    default disable iff (i_srst);

    sequence s_fall;
        pin_fall;
    endsequence

    sequence s_sw_ack_ok;
        sw_ack && (!i_break_state || break_clear_enable_q);
    endsequence

    sequence s_ack_while_low;
        mode_q && latch_q && pin_low && clear_req;
    endsequence

    a_fall_sets_latch:
    assert property (s_fall |=> latch_q)
        else $error("falling edge did not set the latch");

    a_vector_clears:
    assert property (i_vector_fetch && !mode_q && !pin_fall |=> !latch_q)
        else $error("vector fetch did not clear the latch");

    a_soft_ack_clears:
    assert property (s_sw_ack_ok ##0 (!mode_q && !pin_fall) |=> !latch_q)
        else $error("software acknowledge did not clear the latch");

    a_reset_clears_all:
    assert property (disable iff (1'b0)
        i_srst |=> !latch_q && !mode_q && !o_irq_request)
        else $error("reset left latch or mode set");

    a_level_holds_low:
    assert property (s_ack_while_low |=> latch_q ##0 ack_seen_q)
        else $error("level request dropped while pin low");

    a_level_release:
    assert property (ack_seen_q && !pin_low && !pin_fall |=> !latch_q)
        else $error("request stayed after ack and pin high");

    a_new_edge_latches:
    assert property (s_sw_ack_ok ##[1:16] s_fall |=> latch_q)
        else $error("edge after acknowledge was lost");

    a_mask_gates_req:
    assert property (o_irq_request |-> $past(latch_q) && !$past(mask_q))
        else $error("request forwarded while masked");

    a_unmasked_forward:
    assert property (latch_q && !mask_q |=> o_irq_request)
        else $error("unmasked request not forwarded");

    a_break_protects:
    assert property (latch_q && sw_ack && i_break_state && !break_clear_enable_q
        && !i_vector_fetch && !(ack_seen_q && !hold_low) |=> latch_q)
        else $error("acknowledge in break cleared the latch");

    a_ack_reads_zero:
    assert property (o_wb_ack |-> o_wb_dat[irq_pkg::BIT_ACK] == 1'b0
        && o_wb_dat[31:8] == 24'h000000)
        else $error("acknowledge bit or upper bits read nonzero");

    a_pullup_follows:
    assert property (##1 o_pullup_enable == !$past(pud_q))
        else $error("pull-up does not follow the disable bit");

    a_pin_level_seen:
    assert property (o_pin_level == $past(pin_level))
        else $error("pin level output lags wrongly");

endmodule

// *** tb/irq_source_model.sv ***
`timescale 1ns/100ps

module irq_source_model
(
    input  wire logic i_clk,           // System clock
    input  wire logic i_drive_low,     // Source pulls the pin low
    input  wire logic i_pullup_enable, // Pull-up connected
    output logic      o_pin_n          // Resolved pin level
);
    logic flip_q = 1'b0;

    // Floating pin must not settle on a convenient value
    always @(posedge i_clk)
        flip_q <= ~flip_q;

    assign o_pin_n = i_drive_low ? 1'b0 : (i_pullup_enable ? 1'b1 : flip_q);
endmodule

// *** tb/external_irq_latch_bench.sv ***
`timescale 1ns/100ps

module external_irq_latch_bench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0]  sel = 4'hF;
    logic [31:0] rdat;
    logic        ack;
    logic        low = 1'b0;
    logic        vf = 1'b0;
    logic        brk = 1'b0;
    logic        req;
    logic        pue;
    logic        lvl;
    logic        pin_n;
    logic [31:0] rq[$];
    logic [31:0] x = 32'h6143;
    logic [31:0] r;
    int          fails = 0;
    int          compares = 0;

    always #25 clk = ~clk;

    irq_source_model i_src (.i_clk(clk), .i_drive_low(low),
        .i_pullup_enable(pue), .o_pin_n(pin_n));

    external_irq_latch i_dut (.i_sys_clk(clk), .i_srst(srst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_irq_pin_n(pin_n),
        .i_vector_fetch(vf), .i_break_state(brk), .o_irq_request(req),
        .o_pullup_enable(pue), .o_pin_level(lvl));

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        if (n == 20)
        begin
            fails++;
            test_done();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp);
        rq.push_back(exp);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_req(logic v);
        int n;
        for (n = 0; n < 20 && req !== v; n++)
            @(posedge clk);
        if (n == 20)
        begin
            fails++;
            test_done();
        end
    endtask

    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1)
            check("read data", rdat, rq.pop_front());

    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(8'h74, 32'h0000_0000);
        check("pullup", {31'h0, pue}, 32'h1);
        check("pin high", {31'h0, lvl}, 32'h1);
        low <= 1'b1;
        wait_req(1'b1);
        check("pin level", {31'h0, lvl}, 32'h0);
        rd(8'h74, 32'h0000_0008);
        bus(1'b1, 8'h74, 32'h0000_0004);
        wait_req(1'b0);
        rd(8'h74, 32'h0000_0000);
        low <= 1'b0;
        repeat (4) @(posedge clk);
        low <= 1'b1;
        wait_req(1'b1);
        vf <= 1'b1;
        @(posedge clk);
        vf <= 1'b0;
        wait_req(1'b0);
        low <= 1'b0;
        // Masked request still shows as pending
        bus(1'b1, 8'h74, 32'h0000_0002);
        low <= 1'b1;
        repeat (6) @(posedge clk);
        check("masked req", {31'h0, req}, 32'h0);
        rd(8'h74, 32'h0000_000A);
        bus(1'b1, 8'h74, 32'h0000_0006);
        rd(8'h74, 32'h0000_0002);
        low <= 1'b0;
        bus(1'b1, 8'h74, 32'h0000_0001);
        low <= 1'b1;
        wait_req(1'b1);
        // Handler masks further requests while it acknowledges
        bus(1'b1, 8'h74, 32'h0000_0007);
        wait_req(1'b0);
        repeat (4) @(posedge clk);
        rd(8'h74, 32'h0000_000B);
        low <= 1'b0;
        repeat (6) @(posedge clk);
        rd(8'h74, 32'h0000_0003);
        bus(1'b1, 8'h74, 32'h0000_0000);
        brk <= 1'b1;
        low <= 1'b1;
        wait_req(1'b1);
        bus(1'b1, 8'h74, 32'h0000_0004);
        rd(8'h74, 32'h0000_0008);
        bus(1'b1, 8'h7C, 32'h0000_0080);
        bus(1'b1, 8'h74, 32'h0000_0004);
        brk <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h74, 32'h0000_0000);
        rd(8'h7C, 32'h0000_0080);
        low <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            r = xs() & 32'hFFFF_FFFB;
            bus(1'b1, 8'h74, r);
            rd(8'h74, {30'h0, r[1:0]});
            bus(1'b1, 8'h40, xs());
            rd(8'h40, 32'h0000_0000);
        end
        bus(1'b1, 8'h74, 32'h0000_0001);
        bus(1'b1, 8'h78, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check("pullup off", {31'h0, pue}, 32'h0);
        rd(8'h78, 32'h0000_0001);
        low <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check("req after reset", {31'h0, req}, 32'h0);
        repeat (8) @(posedge clk);
        // A pin held low through reset must not latch a new request
        rd(8'h74, 32'h0000_0000);
        check("req held low", {31'h0, req}, 32'h0);
        check("pullup reset", {31'h0, pue}, 32'h1);
        repeat (2) @(posedge clk);
        test_done();
    end
endmodule
